/* ulf_pkg.sv */
// Constants, register map and state types for the serial line format and FIFO level block
package ulf_pkg;
  // ---------------------------------------------------------------
  // FIFO geometry
  // ---------------------------------------------------------------
  localparam logic [3:0] ULF_FIFO_FULL = 4'he + 4'h1;
  localparam logic [3:0] ULF_PTR_LAST = 4'he;
  localparam logic [3:0] ULF_MIN_BITS = 4'h5;
  // ---------------------------------------------------------------
  // Register indexes, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] ULF_IDX_LEVEL = 8'ha5;
  localparam logic [7:0] ULF_IDX_CONFIG = 8'hc2;
  localparam logic [7:0] ULF_IDX_DATA = 8'hc3;
  localparam logic [7:0] ULF_IDX_BAUD = 8'hc4;
  localparam logic [7:0] ULF_IDX_INT_STAT = 8'hc5;
  localparam logic [7:0] ULF_IDX_INT_MASK = 8'hc6;
  // ---------------------------------------------------------------
  // Line configuration fields
  // ---------------------------------------------------------------
  localparam int ULF_CFG_EN = 7;
  localparam int ULF_CFG_SB = 6;
  localparam int ULF_CFG_WLS_HI = 5;
  localparam int ULF_CFG_WLS_LO = 4;
  localparam int ULF_CFG_BRK = 3;
  localparam int ULF_CFG_OP = 2;
  localparam int ULF_CFG_PE = 1;
  localparam int ULF_CFG_SP = 0;
  localparam logic [7:0] ULF_CFG_RESET = 8'h00;
  localparam logic [15:0] ULF_BAUD_RESET = 16'h0000;
  localparam logic [3:0] ULF_THR_RESET = 4'h0;
  localparam logic [3:0] ULF_TX_RESET_CODE = 4'h0;
  localparam logic [3:0] ULF_RX_RESET_CODE = 4'hf;
  // ---------------------------------------------------------------
  // Interrupt status layout
  // ---------------------------------------------------------------
  localparam int ULF_INT_W = 5;
  localparam int ULF_INT_RDA = 0;
  localparam int ULF_INT_TRA = 1;
  localparam int ULF_INT_RFO = 2;
  localparam int ULF_INT_TFO = 3;
  localparam int ULF_INT_RFU = 4;
  localparam logic [ULF_INT_W-1:0] ULF_INT_RESET = 5'h00;
  typedef enum logic [2:0] {ULF_TX_IDLE, ULF_TX_START, ULF_TX_DATA, ULF_TX_PARITY, ULF_TX_STOP} ulf_tx_state_t;
  typedef enum logic [2:0] {ULF_RX_IDLE, ULF_RX_START, ULF_RX_DATA, ULF_RX_PARITY, ULF_RX_STOP} ulf_rx_state_t;
endpackage

/* ulf_uart.sv */
// Serial port with line format control, 15-byte FIFOs and fill level thresholds
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module ulf_uart import ulf_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in,
  output logic serial_out,
  output logic irq
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] ulf_next_ptr(input logic [3:0] p);
    ulf_next_ptr = (p == ULF_PTR_LAST) ? 4'h0 : p + 4'h1;
  endfunction
  function automatic logic [7:0] ulf_mask(input logic [7:0] d, input logic [1:0] word_length_select);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - word_length_select);
    ulf_mask = d & m;
  endfunction
  function automatic logic ulf_parity(input logic [7:0] d, input logic [1:0] word_length_select, input logic odd,
                                      input logic force1);
    ulf_parity = force1 | (odd ^ (^ulf_mask(d, word_length_select)));
  endfunction
  function automatic logic ulf_hit(input logic [11:0] a, input logic [7:0] idx);
    ulf_hit = (a == {2'h0, idx, 2'h0});
  endfunction

  logic [7:0] cfg;
  logic [15:0] baud;
  logic [3:0] rx_thr;
  logic [3:0] tx_thr;
  logic [ULF_INT_W-1:0] int_stat;
  logic [ULF_INT_W-1:0] int_mask;
  logic [7:0] tx_mem [0:14];
  logic [8:0] rx_mem [0:14];
  logic [3:0] tx_rd, tx_wr, tx_count, rx_rd, rx_wr, rx_count;
  ulf_tx_state_t tx_state;
  ulf_rx_state_t rx_state;
  logic [15:0] tx_cnt, rx_cnt;
  logic [7:0] tx_shift, rx_shift;
  logic [3:0] tx_bitn;
  logic [2:0] rx_bitn;
  logic tx_line, tx_par, tx_stop2, rx_pbit;
  logic rx_sync1, rx_sync2;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr_en = acc & pwrite;
  wire rd_en = acc & ~pwrite;
  wire hit_level = ulf_hit(paddr, ULF_IDX_LEVEL);
  wire hit_cfg = ulf_hit(paddr, ULF_IDX_CONFIG);
  wire hit_data = ulf_hit(paddr, ULF_IDX_DATA);
  wire hit_baud = ulf_hit(paddr, ULF_IDX_BAUD);
  wire hit_stat = ulf_hit(paddr, ULF_IDX_INT_STAT);
  wire hit_mask = ulf_hit(paddr, ULF_IDX_INT_MASK);
  wire hit_any = hit_level | hit_cfg | hit_data | hit_baud | hit_stat | hit_mask;
  wire wr_level = wr_en & hit_level;
  wire en = cfg[ULF_CFG_EN];
  wire pe = cfg[ULF_CFG_PE];
  wire [1:0] word_length_select = cfg[ULF_CFG_WLS_HI:ULF_CFG_WLS_LO];
  wire [3:0] nbits = ULF_MIN_BITS + {2'h0, word_length_select};
  wire clear_all = ~en & (baud == ULF_BAUD_RESET);
  wire tx_reset = clear_all | (wr_level & (pwdata[3:0] == ULF_TX_RESET_CODE));
  wire rx_reset = clear_all | (wr_level & (pwdata[7:4] == ULF_RX_RESET_CODE));
  wire head_parity_error_flag = (rx_count != 4'h0) & rx_mem[rx_rd][8];
  wire [7:0] cfg_rd = {cfg[7:2], head_parity_error_flag, cfg[ULF_CFG_SP]};
  wire [31:0] rd_mux = hit_level ? {24'h0000_00, rx_count, tx_count} :
                       hit_cfg ? {24'h0000_00, cfg_rd} :
                       hit_data ? {24'h0000_00, rx_mem[rx_rd][7:0]} :
                       hit_baud ? {16'h0000, baud} :
                       hit_stat ? {27'h0000_000, int_stat} :
                       hit_mask ? {27'h0000_000, int_mask} : 32'h0000_0000;

  assign pready = 1'b1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= setup ? rd_mux : prdata;
      pslverr <= setup & ~hit_any;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= ULF_CFG_RESET;
      baud <= ULF_BAUD_RESET;
      rx_thr <= ULF_THR_RESET;
      tx_thr <= ULF_THR_RESET;
      int_mask <= ULF_INT_RESET;
    end else begin
      if (wr_en & hit_cfg) begin
        cfg <= pwdata[7:0];
      end
      if (wr_en & hit_baud) begin
        baud <= pwdata[15:0];
      end
      if (wr_level) begin
        rx_thr <= pwdata[7:4];
        tx_thr <= pwdata[3:0];
      end
      if (wr_en & hit_mask) begin
        int_mask <= pwdata[ULF_INT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // FIFOs
  // ---------------------------------------------------------------
  wire tx_push_req = wr_en & hit_data;
  wire tx_push = tx_push_req & (tx_count != ULF_FIFO_FULL) & ~tx_reset;
  wire tx_pop = (tx_state == ULF_TX_IDLE) & en & (tx_count != 4'h0) & ~tx_reset;
  wire rx_pop_req = rd_en & hit_data;
  wire rx_pop = rx_pop_req & (rx_count != 4'h0) & ~rx_reset;
  wire rx_tick = (rx_cnt == 16'h0000);
  wire rx_done = (rx_state == ULF_RX_STOP) & rx_tick & ~rx_reset;
  wire rx_push = rx_done & (rx_count != ULF_FIFO_FULL);
  wire rx_parity_error_flag = pe & (rx_pbit != ulf_parity(rx_shift, word_length_select, cfg[ULF_CFG_OP], cfg[ULF_CFG_SP]));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_rd <= 4'h0;
      tx_wr <= 4'h0;
      tx_count <= 4'h0;
    end else if (tx_reset) begin
      tx_rd <= 4'h0;
      tx_wr <= 4'h0;
      tx_count <= 4'h0;
    end else begin
      tx_wr <= tx_push ? ulf_next_ptr(tx_wr) : tx_wr;
      tx_rd <= tx_pop ? ulf_next_ptr(tx_rd) : tx_rd;
      tx_count <= tx_count + {3'h0, tx_push} - {3'h0, tx_pop};
    end
  end

  always_ff @(posedge clock) begin
    if (tx_push) begin
      tx_mem[tx_wr] <= pwdata[7:0];
    end
    if (rx_push) begin
      rx_mem[rx_wr] <= {rx_parity_error_flag, ulf_mask(rx_shift, word_length_select)};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_rd <= 4'h0;
      rx_wr <= 4'h0;
      rx_count <= 4'h0;
    end else if (rx_reset) begin
      rx_rd <= 4'h0;
      rx_wr <= 4'h0;
      rx_count <= 4'h0;
    end else begin
      rx_wr <= rx_push ? ulf_next_ptr(rx_wr) : rx_wr;
      rx_rd <= rx_pop ? ulf_next_ptr(rx_rd) : rx_rd;
      rx_count <= rx_count + {3'h0, rx_push} - {3'h0, rx_pop};
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  wire tx_tick = (tx_cnt == 16'h0000);
  wire tx_last = (tx_bitn == nbits);
  wire [15:0] next_tx_cnt = ((tx_state == ULF_TX_IDLE) | tx_tick) ? baud : tx_cnt - 16'h0001;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt <= ULF_BAUD_RESET;
    end else begin
      tx_cnt <= next_tx_cnt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= ULF_TX_IDLE;
      tx_line <= 1'b1;
      tx_shift <= 8'h00;
      tx_bitn <= 4'h0;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
    end else if (tx_reset) begin
      tx_state <= ULF_TX_IDLE;
      tx_line <= 1'b1;
    end else begin
      case (tx_state)
        ULF_TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_pop) begin
            tx_shift <= tx_mem[tx_rd];
            tx_par <= ulf_parity(tx_mem[tx_rd], word_length_select, cfg[ULF_CFG_OP], cfg[ULF_CFG_SP]);
            tx_line <= 1'b0;
            tx_state <= ULF_TX_START;
          end
        end
        ULF_TX_START: begin
          if (tx_tick) begin
            tx_line <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_bitn <= 4'h1;
            tx_state <= ULF_TX_DATA;
          end
        end
        ULF_TX_DATA: begin
          if (tx_tick && tx_last) begin
            tx_line <= pe ? tx_par : 1'b1;
            tx_stop2 <= cfg[ULF_CFG_SB];
            tx_state <= pe ? ULF_TX_PARITY : ULF_TX_STOP;
          end else if (tx_tick) begin
            tx_line <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_bitn <= tx_bitn + 4'h1;
          end
        end
        ULF_TX_PARITY: begin
          if (tx_tick) begin
            tx_line <= 1'b1;
            tx_state <= ULF_TX_STOP;
          end
        end
        ULF_TX_STOP: begin
          if (tx_tick && tx_stop2) begin
            tx_stop2 <= 1'b0;
          end else if (tx_tick) begin
            tx_state <= ULF_TX_IDLE;
          end
        end
        default: begin
          tx_state <= ULF_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= tx_line & ~cfg[ULF_CFG_BRK];
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  wire [15:0] next_rx_cnt = (rx_state == ULF_RX_IDLE) ? (baud >> 1) :
                            rx_tick ? baud : rx_cnt - 16'h0001;
  wire rx_last = ({1'b0, rx_bitn} == nbits - 4'h1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      rx_cnt <= ULF_BAUD_RESET;
    end else begin
      rx_sync1 <= serial_in;
      rx_sync2 <= rx_sync1;
      rx_cnt <= next_rx_cnt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= ULF_RX_IDLE;
      rx_shift <= 8'h00;
      rx_bitn <= 3'h0;
      rx_pbit <= 1'b0;
    end else if (rx_reset) begin
      rx_state <= ULF_RX_IDLE;
    end else begin
      case (rx_state)
        ULF_RX_IDLE: begin
          if (en && !rx_sync2) begin
            rx_state <= ULF_RX_START;
          end
        end
        ULF_RX_START: begin
          if (rx_tick) begin
            rx_shift <= 8'h00;
            rx_bitn <= 3'h0;
            rx_state <= rx_sync2 ? ULF_RX_IDLE : ULF_RX_DATA;
          end
        end
        ULF_RX_DATA: begin
          if (rx_tick) begin
            rx_shift[rx_bitn] <= rx_sync2;
            rx_bitn <= rx_bitn + 3'h1;
            if (rx_last) begin
              rx_state <= pe ? ULF_RX_PARITY : ULF_RX_STOP;
            end
          end
        end
        ULF_RX_PARITY: begin
          if (rx_tick) begin
            rx_pbit <= rx_sync2;
            rx_state <= ULF_RX_STOP;
          end
        end
        ULF_RX_STOP: begin
          if (rx_tick) begin
            rx_state <= ULF_RX_IDLE;
          end
        end
        default: begin
          rx_state <= ULF_RX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  wire [ULF_INT_W-1:0] ev;
  assign ev[ULF_INT_RDA] = rx_count > rx_thr;
  assign ev[ULF_INT_TRA] = tx_count < tx_thr;
  assign ev[ULF_INT_RFO] = rx_done & (rx_count == ULF_FIFO_FULL);
  assign ev[ULF_INT_TFO] = tx_push_req & (tx_count == ULF_FIFO_FULL);
  assign ev[ULF_INT_RFU] = rx_pop_req & (rx_count == 4'h0);
  wire [ULF_INT_W-1:0] w1c = (wr_en & hit_stat) ? pwdata[ULF_INT_W-1:0] : ULF_INT_RESET;
  wire [ULF_INT_W-1:0] fifo_clr = clear_all ? 5'h1c : ULF_INT_RESET;
  wire [ULF_INT_W-1:0] next_int_stat = (int_stat & ~w1c & ~fifo_clr) | ev;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= ULF_INT_RESET;
      irq <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq <= |(next_int_stat & int_mask);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_last_data_tick;
    tx_state == ULF_TX_DATA && tx_tick && tx_last && !tx_reset;
  endsequence
  sequence s_level_read;
    setup && hit_level && !pwrite;
  endsequence

  property p_break_low;
    cfg[ULF_CFG_BRK] |=> !serial_out;
  endproperty
  a_break_low: assert property (p_break_low) else $error("line not low during break");
  property p_fifo_cap;
    tx_count <= ULF_FIFO_FULL && rx_count <= ULF_FIFO_FULL;
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("fifo count above capacity");
  property p_rx_level_read;
    s_level_read |=> prdata[7:4] == $past(rx_count) && prdata[3:0] == $past(tx_count);
  endproperty
  a_rx_level_read: assert property (p_rx_level_read) else $error("level read mismatch");
  property p_rda;
    rx_count > rx_thr |=> int_stat[ULF_INT_RDA];
  endproperty
  a_rda: assert property (p_rda) else $error("receive event not raised");
  property p_disabled_idle;
    !en && tx_state == ULF_TX_IDLE |=> tx_state == ULF_TX_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("transmit started while disabled");
  property p_two_stops;
    tx_state == ULF_TX_STOP && tx_tick && tx_stop2 && !tx_reset |=> tx_state == ULF_TX_STOP [*2];
  endproperty
  a_two_stops: assert property (p_two_stops) else $error("second stop bit missing");
  property p_force_one;
    s_last_data_tick ##0 (pe && cfg[ULF_CFG_SP]) |=> tx_line ##1 tx_line;
  endproperty
  a_force_one: assert property (p_force_one) else $error("forced parity not one");
  property p_clear_all;
    clear_all |=> tx_count == 4'h0 && rx_count == 4'h0 && tx_state == ULF_TX_IDLE;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear did not empty fifos");
  property p_tx_reset;
    wr_level && pwdata[3:0] == ULF_TX_RESET_CODE |=> tx_count == 4'h0;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("transmit reset code ignored");
  property p_rx_thr;
    wr_level |=> rx_thr == $past(pwdata[7:4]);
  endproperty
  a_rx_thr: assert property (p_rx_thr) else $error("receive threshold not loaded");
endmodule

/* ulf_remote_node.sv */
// Remote serial node model facing the line pins of the serial port
`timescale 1ns/10ps
module ulf_remote_node #(
  parameter int BIT_CLKS = 8
) (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  int cyc = 0;
  initial line_out = 1'b1;
  always @(posedge clock) cyc <= cyc + 1;
  // ---------------------------------------------------------------
  // Send one frame, one stop bit, line back to idle high
  // ---------------------------------------------------------------
  task automatic send(input int nb, input logic [7:0] d, input bit pe, input logic pb);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (BIT_CLKS) @(posedge clock);
    end
    if (pe) begin
      line_out <= pb;
      repeat (BIT_CLKS) @(posedge clock);
    end
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clock);
  endtask
  // ---------------------------------------------------------------
  // Receive one frame, sampling mid-bit; t0 is the start edge cycle
  // ---------------------------------------------------------------
  task automatic recv(input int nb, input bit pe, output logic [7:0] d, output logic p, output logic s,
                      output int t0);
    d = 8'h00;
    p = 1'b0;
    do @(posedge clock); while (line_in !== 1'b0);
    t0 = cyc;
    repeat (BIT_CLKS / 2) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(posedge clock);
      d[i] = line_in;
    end
    if (pe) begin
      repeat (BIT_CLKS) @(posedge clock);
      p = line_in;
    end
    repeat (BIT_CLKS) @(posedge clock);
    s = line_in;
  endtask
endmodule

/* test_ulf_uart.sv */
// Self-checking testbench for the serial line format and FIFO level block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module test_ulf_uart import ulf_pkg::*;;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, serial_in, serial_out, irq, er, p0, p1, s0, s1, pb;
  logic [7:0] d0, d1, mk;
  int err_total = 0, checks = 0, cycles = 0, t0, t1, nb, n;
  bit sb, pe;
  logic [7:0] tdat [2] = '{8'hb5, 8'h4e};
  bit op_t [4] = '{1, 0, 1, 0};
  bit sp_t [4] = '{0, 0, 1, 0};
  ulf_uart u_ulf_uart (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in(serial_in), .serial_out(serial_out), .irq(irq));
  ulf_remote_node #(.BIT_CLKS(8)) u_ulf_remote_node (.clock(clock), .line_in(serial_out), .line_out(serial_in));
  initial forever #4 clock = ~clock;
  // ---------------------------------------------------------------
  // Bus tasks and helpers
  // ---------------------------------------------------------------
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rdv(input logic [7:0] idx);
    apb(idx, 1'b0, 32'h0000_0000);
  endtask
  function automatic logic [31:0] cfg(bit en, bit s2, logic [1:0] wl, bit brk, bit op, bit pen, bit sp);
    return {24'h00_0000, en, s2, wl, brk, op, pen, sp};
  endfunction
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `CHK("serial_out idle", 1'b1, serial_out)
    `CHK("pready", 1'b1, pready)
    rdv(ULF_IDX_CONFIG); `CHK("config reset", 32'h0000_0000, rd)
    rdv(ULF_IDX_LEVEL); `CHK("level reset", 32'h0000_0000, rd)
    rdv(8'h00); `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    wr(ULF_IDX_BAUD, 32'h0000_0007);
    for (int k = 0; k < 4; k++) begin
      nb = k + 5;
      sb = k[0];
      pe = (k != 3);
      mk = 8'hff >> (3 - k);
      wr(ULF_IDX_CONFIG, cfg(1, sb, k[1:0], 0, op_t[k], pe, sp_t[k]));
      fork
        begin
          u_ulf_remote_node.recv(nb, pe, d0, p0, s0, t0);
          u_ulf_remote_node.recv(nb, pe, d1, p1, s1, t1);
        end
        begin
          wr(ULF_IDX_DATA, {24'h00_0000, tdat[0]});
          wr(ULF_IDX_DATA, {24'h00_0000, tdat[1]});
        end
      join
      `CHK("tx data", tdat[0] & mk, d0)
      `CHK("tx data2", tdat[1] & mk, d1)
      pb = sp_t[k] ? 1'b1 : (op_t[k] ? ~^(tdat[0] & mk) : ^(tdat[0] & mk));
      if (pe) `CHK("tx parity", pb, p0)
      `CHK("stop level", 1'b1, s0)
      `CHK("frame gap", (2 + nb + pe + sb) * 8 + 1, t1 - t0)
      repeat (30) @(posedge clock);
    end
    wr(ULF_IDX_CONFIG, cfg(1, 0, 2'b11, 1, 0, 0, 0));
    n = 0;
    repeat (3) @(posedge clock);
    repeat (40) begin
      @(posedge clock);
      if (serial_out === 1'b0) n++;
    end
    `CHK("break low", 40, n)
    wr(ULF_IDX_CONFIG, cfg(1, 0, 2'b11, 0, 0, 0, 0));
    repeat (3) @(posedge clock);
    `CHK("break released", 1'b1, serial_out)
    wr(ULF_IDX_CONFIG, cfg(1, 0, 2'b11, 0, 0, 1, 0));
    wr(ULF_IDX_LEVEL, 32'h0000_0010);
    wr(ULF_IDX_INT_MASK, 32'h0000_0001);
    u_ulf_remote_node.send(8, 8'h3c, 1, ^8'h3c);
    repeat (6) @(posedge clock);
    rdv(ULF_IDX_LEVEL); `CHK("rx count one", 32'h0000_0010, rd)
    rdv(ULF_IDX_INT_STAT); `CHK("rx event low", 1'b0, rd[ULF_INT_RDA])
    `CHK("irq low", 1'b0, irq)
    u_ulf_remote_node.send(8, 8'ha7, 1, ~^8'ha7);
    repeat (6) @(posedge clock);
    rdv(ULF_IDX_INT_STAT); `CHK("rx event high", 1'b1, rd[ULF_INT_RDA])
    `CHK("irq high", 1'b1, irq)
    wr(ULF_IDX_INT_MASK, 32'h0000_0000);
    @(posedge clock);
    `CHK("irq masked", 1'b0, irq)
    for (int k = 0; k < 4; k++) begin
      wr(ULF_IDX_LEVEL, {24'h00_0000, k[3:0], 4'h0});
      wr(ULF_IDX_INT_STAT, 32'h0000_0001);
      rdv(ULF_IDX_INT_STAT); `CHK("rx threshold", (k < 2), rd[ULF_INT_RDA])
    end
    wr(ULF_IDX_LEVEL, 32'h0000_0010);
    wr(ULF_IDX_INT_MASK, 32'h0000_0001);
    rdv(ULF_IDX_CONFIG); `CHK("head parity ok", 1'b0, rd[ULF_CFG_PE])
    rdv(ULF_IDX_DATA); `CHK("rx byte one", 32'h0000_003c, rd)
    rdv(ULF_IDX_CONFIG); `CHK("head parity bad", 1'b1, rd[ULF_CFG_PE])
    wr(ULF_IDX_INT_STAT, 32'h0000_0001);
    rdv(ULF_IDX_INT_STAT); `CHK("rx event cleared", 1'b0, rd[ULF_INT_RDA])
    `CHK("irq cleared", 1'b0, irq)
    rdv(ULF_IDX_DATA); `CHK("rx byte two", 32'h0000_00a7, rd)
    rdv(ULF_IDX_DATA);
    rdv(ULF_IDX_INT_STAT); `CHK("rx underflow", 1'b1, rd[ULF_INT_RFU])
    wr(ULF_IDX_CONFIG, cfg(0, 0, 2'b11, 0, 0, 0, 0));
    repeat (30) @(posedge clock);
    wr(ULF_IDX_DATA, 32'h0000_0011);
    wr(ULF_IDX_DATA, 32'h0000_0022);
    repeat (40) @(posedge clock);
    rdv(ULF_IDX_LEVEL); `CHK("tx held", 32'h0000_0002, rd)
    wr(ULF_IDX_LEVEL, 32'h0000_0025);
    rdv(ULF_IDX_LEVEL); `CHK("threshold hidden", 32'h0000_0002, rd)
    rdv(ULF_IDX_INT_STAT); `CHK("tx room", 1'b1, rd[ULF_INT_TRA])
    wr(ULF_IDX_LEVEL, 32'h0000_0020);
    rdv(ULF_IDX_LEVEL); `CHK("tx reset code", 32'h0000_0000, rd)
    u_ulf_remote_node.send(8, 8'h55, 0, 1'b0);
    repeat (6) @(posedge clock);
    rdv(ULF_IDX_LEVEL); `CHK("rx disabled", 32'h0000_0000, rd)
    repeat (16) wr(ULF_IDX_DATA, 32'h0000_0044);
    rdv(ULF_IDX_LEVEL); `CHK("tx full", 32'h0000_000f, rd)
    rdv(ULF_IDX_INT_STAT); `CHK("tx overflow", 1'b1, rd[ULF_INT_TFO])
    wr(ULF_IDX_DATA, 32'h0000_0033);
    wr(ULF_IDX_BAUD, 32'h0000_0000);
    rdv(ULF_IDX_LEVEL); `CHK("clear fifo", 32'h0000_0000, rd)
    rdv(ULF_IDX_INT_STAT); `CHK("clear flags", 1'b0, rd[ULF_INT_RFU])
    `CHK("clear tx flag", 1'b0, rd[ULF_INT_TFO])
    test_done();
  end
endmodule
